// file: design/cprg_alg_decode.sv
// decoder from cache-algorithm code to access class
`timescale 1ns/1ps
module cprg_alg_decode (
  input wire logic [1:0] seg,
  input wire logic [2:0] tlb_alg,
  input wire logic [2:0] unmapped_segment_policy,
  input wire logic [63:0] vaddr,
  output logic uncached,
  output logic accel,
  output logic [2:0] alg
);
  always_comb begin
    unique case (cprg_pkg::cprg_seg_type'(seg))
      cprg_pkg::SRC_MAPPED: alg = tlb_alg;
      cprg_pkg::SRC_UNMAPPED: alg = unmapped_segment_policy;
      cprg_pkg::SRC_DIRECT: alg = vaddr[61:59];
      default: alg = tlb_alg;
    endcase
    // reserved codes fall back to uncached
    uncached = !(alg == cprg_pkg::ALG_NONCOH || alg == cprg_pkg::ALG_COH_EXCL ||
                 alg == cprg_pkg::ALG_COH_EXCL_WR);
    accel = (alg == cprg_pkg::ALG_UNC_ACCEL);
  end
endmodule // cprg_alg_decode

// file: design/cprg_pkg.sv
// package for the cache policy request generator
package cprg_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_ACCESS = 8'h04;
  localparam logic [7:0] REG_LINE = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_REQUEST = 8'h10;
  localparam logic [7:0] REG_RESPONSE = 8'h14;
  localparam logic [7:0] REG_UCB = 8'h18;
  // config fields
  localparam int CFG_CAP_LSB = 0;
  localparam int CFG_LINE_BIT = 4;
  localparam int CFG_POL_LSB = 8;
  localparam logic [2:0] CAP_MAX = 3'h5;
  localparam logic [2:0] CFG_POL_RESET = 3'h3;
  localparam int CAP_MIN_KB = 512;
  localparam int LINE_WORDS_SHORT = 16;
  localparam int LINE_WORDS_LONG = 32;
  // cache algorithm codes
  localparam logic [2:0] ALG_UNCACHED = 3'h2;
  localparam logic [2:0] ALG_NONCOH = 3'h3;
  localparam logic [2:0] ALG_COH_EXCL = 3'h4;
  localparam logic [2:0] ALG_COH_EXCL_WR = 3'h5;
  localparam logic [2:0] ALG_UNC_ACCEL = 3'h7;
  localparam int UCB_DEPTH = 8;
  localparam int GATHER_WORDS = 8;

  typedef enum logic [1:0] {
    LS_INVALID,
    LS_CLEAN_EXCL,
    LS_DIRTY_EXCL,
    LS_SHARED
  } cprg_line_state_type;

  typedef enum logic [3:0] {
    RQ_NONE,
    RQ_UNC_READ,
    RQ_UNC_WRITE,
    RQ_NONCOH_BLOCK_READ,
    RQ_COH_READ_EXCL,
    RQ_COH_READ_SHARED,
    RQ_UPGRADE,
    RQ_BLOCK_WRITE,
    RQ_WRITEBACK
  } cprg_req_kind_type;

  typedef enum logic [1:0] {
    SRC_MAPPED,
    SRC_UNMAPPED,
    SRC_DIRECT
  } cprg_seg_type;

  // access size: 0 partial, 1 word, 2 doubleword
  typedef struct packed {
    cprg_req_kind_type kind;
    logic [1:0] size;
    logic [31:0] addr;
  } cprg_req_type;

  typedef struct packed {
    logic [31:0] addr;
    logic [1:0] size;
    logic store;
    logic accel;
  } cprg_ucb_entry_type;
endpackage

// file: design/cprg_top.sv
// cache policy request generator with apb registers
`timescale 1ns/1ps
module cprg_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sys_accept,
  output logic sys_req_valid,
  output cprg_pkg::cprg_req_type sys_req,
  output logic barrier_hold
);
  // register state
  logic [2:0] cap_q;
  logic line_long_q;
  logic [2:0] pol_q;
  logic [31:0] acc_addr_q;
  cprg_pkg::cprg_line_state_type ways_q [2];
  logic [1:0] way_valid_q;
  logic lru_q;
  logic owned_q;
  logic l1_dirty_q;
  logic pend_data_q;
  logic pend_ack_q;
  logic upg_pend_q;
  logic bar_q;
  logic unc_load_wait_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic req_valid_q;
  // set while the request on the port came from the uncached buffer head
  logic req_ucb_q;
  cprg_pkg::cprg_req_type req_q;
  // gather state for accelerated stores
  logic [31:0] g_base_q;
  logic [3:0] g_words_q;
  logic g_active_q;

  logic setup;
  logic wr_en;
  logic [31:0] wd;
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && pready_q;
  assign wd = pwdata;

  // access register fields
  logic [1:0] a_seg;
  logic [2:0] a_tlb;
  logic [1:0] a_size;
  logic a_store;
  logic a_go;
  logic a_cache_op;
  logic a_l1_dirty;
  logic [63:0] a_va;
  assign a_seg = wd[1:0];
  assign a_tlb = wd[4:2];
  assign a_size = wd[6:5];
  assign a_store = wd[7];
  assign a_go = wr_en && paddr == cprg_pkg::REG_ACCESS;
  assign a_cache_op = wd[8];
  assign a_l1_dirty = wd[9];
  assign a_va = {2'h0, wd[12:10], 59'h0};

  logic dec_unc;
  logic dec_acc;
  logic [2:0] dec_alg;
  cprg_alg_decode u_dec (
    .seg(a_seg),
    .tlb_alg(a_tlb),
    .unmapped_segment_policy(pol_q),
    .vaddr(a_va),
    .uncached(dec_unc),
    .accel(dec_acc),
    .alg(dec_alg)
  );

  // lookup: a way hits when it is valid and not LS_INVALID; no address tag is compared
  logic [1:0] hit_vec;
  logic hit;
  logic hit_way;
  always_comb begin
    for (int w = 0; w < 2; w++) begin
      hit_vec[w] = way_valid_q[w] && ways_q[w] != cprg_pkg::LS_INVALID;
    end
    hit = |hit_vec;
    hit_way = hit_vec[1] && !hit_vec[0];
  end

  // uncached buffer
  logic ucb_push;
  cprg_pkg::cprg_ucb_entry_type ucb_in;
  logic ucb_pop;
  cprg_pkg::cprg_ucb_entry_type ucb_head;
  logic ucb_empty;
  logic ucb_full;
  logic ucb_plain;
  logic g_flush;
  logic g_full_line;
  logic unc_access;
  logic gatherable;
  assign unc_access = a_go && dec_unc && !a_cache_op;
  assign gatherable = a_store && dec_acc && a_size != 2'h0;
  assign g_full_line = g_active_q && g_words_q == 4'(cprg_pkg::GATHER_WORDS);
  // a gather ends when an uncached access other than a gatherable store to the base or the next sequential word arrives, or the line is full
  assign g_flush = g_active_q && (g_full_line ||
                   (unc_access && !(gatherable && (acc_addr_q == g_base_q ||
                   acc_addr_q == g_base_q + {26'h0, g_words_q, 2'h0}))));
  assign ucb_push = (unc_access && !gatherable) || g_flush;
  always_comb begin
    ucb_in.addr = acc_addr_q;
    ucb_in.size = a_size;
    ucb_in.store = a_store;
    ucb_in.accel = dec_acc;
    if (g_flush) begin
      ucb_in.addr = g_base_q;
      ucb_in.size = g_full_line ? 2'h3 : 2'h2;
      ucb_in.store = 1'b1;
      ucb_in.accel = 1'b1;
    end
  end
  // only an accepted buffer request retires the head entry
  assign ucb_pop = sys_accept && req_valid_q && req_ucb_q;

  cprg_ucb #(
    .DEPTH(cprg_pkg::UCB_DEPTH)
  ) u_ucb (
    .mclk(mclk),
    .rst(rst),
    .push(ucb_push),
    .push_entry(ucb_in),
    .pop(ucb_pop),
    .head(ucb_head),
    .empty(ucb_empty),
    .full(ucb_full),
    .plain_store_pending(ucb_plain)
  );

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      g_active_q <= 1'b0;
      g_base_q <= '0;
      g_words_q <= '0;
    end else if (unc_access && gatherable && !g_flush && g_active_q) begin
      if (acc_addr_q != g_base_q) g_words_q <= g_words_q + 4'h1;
    end else if (unc_access && gatherable) begin
      g_active_q <= 1'b1;
      g_base_q <= acc_addr_q;
      g_words_q <= 4'h1;
    end else if (g_flush) begin
      g_active_q <= 1'b0;
      g_words_q <= '0;
    end
  end

  // configuration register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cap_q <= '0;
      line_long_q <= 1'b0;
      pol_q <= cprg_pkg::CFG_POL_RESET;
    end else if (wr_en && paddr == cprg_pkg::REG_CONFIG) begin
      if (wd[cprg_pkg::CFG_CAP_LSB +: 3] <= cprg_pkg::CAP_MAX) begin
        cap_q <= wd[cprg_pkg::CFG_CAP_LSB +: 3];
      end
      line_long_q <= wd[cprg_pkg::CFG_LINE_BIT];
      pol_q <= wd[cprg_pkg::CFG_POL_LSB +: 3];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc_addr_q <= '0;
    end else if (wr_en && paddr == cprg_pkg::REG_LINE) begin
      acc_addr_q <= wd;
    end
  end

  // request generation; cached requests never wait behind queued uncached traffic
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      req_valid_q <= 1'b0;
      req_ucb_q <= 1'b0;
      req_q <= '0;
    end else if (req_valid_q && !sys_accept) begin
      req_valid_q <= 1'b1;
    end else if (a_go && !dec_unc && !a_cache_op) begin
      // cached requests do not look at the buffer
      req_valid_q <= 1'b0;
      req_ucb_q <= 1'b0;
      req_q.addr <= acc_addr_q;
      req_q.size <= 2'h2;
      if (hit && a_store && ways_q[hit_way] == cprg_pkg::LS_SHARED) begin
        req_valid_q <= 1'b1;
        req_q.kind <= cprg_pkg::RQ_UPGRADE;
      end else if (hit && a_store) begin
        req_q.kind <= cprg_pkg::RQ_NONE;
      end else if (!hit) begin
        req_valid_q <= 1'b1;
        unique case (dec_alg)
          cprg_pkg::ALG_NONCOH: req_q.kind <= cprg_pkg::RQ_NONCOH_BLOCK_READ;
          cprg_pkg::ALG_COH_EXCL: req_q.kind <= cprg_pkg::RQ_COH_READ_EXCL;
          default: req_q.kind <= a_store ? cprg_pkg::RQ_COH_READ_EXCL :
                                            cprg_pkg::RQ_COH_READ_SHARED;
        endcase
      end
    end else if (!ucb_empty && !(req_valid_q && ucb_pop)) begin
      req_valid_q <= 1'b1;
      req_ucb_q <= 1'b1;
      req_q.addr <= ucb_head.addr;
      req_q.size <= ucb_head.size;
      if (ucb_head.store && ucb_head.size == 2'h3) begin
        req_q.kind <= cprg_pkg::RQ_BLOCK_WRITE;
      end else begin
        req_q.kind <= ucb_head.store ? cprg_pkg::RQ_UNC_WRITE : cprg_pkg::RQ_UNC_READ;
      end
    end else if (wr_en && paddr == cprg_pkg::REG_REQUEST && wd[0]) begin
      // writeback of the line held in REG_LINE (acc_addr_q), only once l1 has been merged
      // a refused writeback must not leave a just-accepted request standing
      req_valid_q <= !l1_dirty_q;
      req_ucb_q <= 1'b0;
      if (!l1_dirty_q) begin
        req_q.kind <= cprg_pkg::RQ_WRITEBACK;
        req_q.addr <= acc_addr_q;
        req_q.size <= 2'h3;
      end
    end else if (sys_accept) begin
      req_valid_q <= 1'b0;
    end
  end

  // line state, lru and ownership
  logic victim;
  assign victim = lru_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ways_q[0] <= cprg_pkg::LS_INVALID;
      ways_q[1] <= cprg_pkg::LS_INVALID;
      way_valid_q <= '0;
      lru_q <= 1'b0;
      owned_q <= 1'b0;
      l1_dirty_q <= 1'b0;
      pend_data_q <= 1'b0;
      pend_ack_q <= 1'b0;
      upg_pend_q <= 1'b0;
    end else begin
      if (a_go && !dec_unc) begin
        l1_dirty_q <= a_l1_dirty;
        if (a_cache_op) begin
          ways_q[hit_way] <= cprg_pkg::LS_INVALID;
          owned_q <= 1'b0;
        end else if (hit) begin
          lru_q <= !hit_way;
          if (a_store && ways_q[hit_way] == cprg_pkg::LS_CLEAN_EXCL) begin
            ways_q[hit_way] <= cprg_pkg::LS_DIRTY_EXCL;
            owned_q <= 1'b1;
          end else if (a_store && ways_q[hit_way] == cprg_pkg::LS_SHARED) begin
            upg_pend_q <= 1'b1;
          end
        end else begin
          way_valid_q[victim] <= 1'b1;
          ways_q[victim] <= cprg_pkg::LS_INVALID;
          lru_q <= !victim;
          pend_data_q <= 1'b1;
          pend_ack_q <= 1'b1;
        end
      end
      // response register: bit0 last data, bit1 ack, bits3:2 returned state
      if (wr_en && paddr == cprg_pkg::REG_RESPONSE) begin
        if (wd[0] && pend_data_q) begin
          pend_data_q <= 1'b0;
          ways_q[!lru_q] <= cprg_pkg::cprg_line_state_type'(wd[3:2]);
        end
        if (wd[1]) begin
          pend_ack_q <= 1'b0;
          if (upg_pend_q) begin
            upg_pend_q <= 1'b0;
            ways_q[hit_way] <= cprg_pkg::LS_DIRTY_EXCL;
            owned_q <= 1'b1;
          end
        end
        if ((wd[0] || !pend_data_q) && (wd[1] || !pend_ack_q) &&
            (pend_data_q || pend_ack_q)) begin
          // the state comes with the last data, which may precede the ack
          owned_q <= (wd[0] ? cprg_pkg::cprg_line_state_type'(wd[3:2]) : ways_q[!lru_q]) ==
                     cprg_pkg::LS_DIRTY_EXCL;
        end
        // external intervention: bit4 shared, bit5 exclusive/invalidate
        if (wd[4] && hit) begin
          ways_q[hit_way] <= cprg_pkg::LS_SHARED;
          owned_q <= 1'b0;
        end
        if (wd[5] && hit) begin
          ways_q[hit_way] <= cprg_pkg::LS_INVALID;
          owned_q <= 1'b0;
        end
      end
    end
  end

  // barrier and uncached load completion
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bar_q <= 1'b0;
      unc_load_wait_q <= 1'b0;
    end else begin
      if (wr_en && paddr == cprg_pkg::REG_UCB && wd[0]) bar_q <= 1'b1;
      else if (!ucb_plain) bar_q <= 1'b0;
      if (unc_access && !a_store) unc_load_wait_q <= 1'b1;
      else if (ucb_empty && !req_valid_q) unc_load_wait_q <= 1'b0;
    end
  end

  // apb slave, zero wait state
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
      if (setup) begin
        unique case (paddr)
          cprg_pkg::REG_CONFIG: prdata_q <= {21'h0, pol_q, 3'h0, line_long_q, 1'b0, cap_q};
          cprg_pkg::REG_LINE: prdata_q <= acc_addr_q;
          cprg_pkg::REG_STATUS: prdata_q <= {21'h0, g_active_q, owned_q, lru_q,
                                             ways_q[1], ways_q[0], upg_pend_q,
                                             pend_ack_q, pend_data_q, l1_dirty_q};
          cprg_pkg::REG_UCB: prdata_q <= {28'h0, unc_load_wait_q, bar_q, ucb_full,
                                          ucb_empty};
          cprg_pkg::REG_ACCESS, cprg_pkg::REG_REQUEST, cprg_pkg::REG_RESPONSE:
            prdata_q <= '0;
          default: pslverr_q <= 1'b1;
        endcase
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign sys_req_valid = req_valid_q;
  assign sys_req = req_q;
  assign barrier_hold = bar_q;
endmodule // cprg_top

// file: design/cprg_ucb.sv
// in-order uncached buffer
`timescale 1ns/1ps
module cprg_ucb #(
  parameter int DEPTH = cprg_pkg::UCB_DEPTH
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic push,
  input wire cprg_pkg::cprg_ucb_entry_type push_entry,
  input wire logic pop,
  output cprg_pkg::cprg_ucb_entry_type head,
  output logic empty,
  output logic full,
  output logic plain_store_pending
);
  localparam int AW = $clog2(DEPTH);
  cprg_pkg::cprg_ucb_entry_type mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] plain_q;
  logic do_push;
  logic do_pop;
  logic push_plain;
  logic pop_plain;
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign push_plain = do_push && push_entry.store && !push_entry.accel;
  assign pop_plain = do_pop && head.store && !head.accel;
  assign empty = (cnt_q == '0);
  assign full = (cnt_q == (AW+1)'(DEPTH));
  assign head = mem[rd_q];
  assign plain_store_pending = (plain_q != '0);
  always_ff @(posedge mclk) begin
    if (do_push) begin
      mem[wr_q] <= push_entry;
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      plain_q <= '0;
    end else begin
      if (do_push) wr_q <= wr_q + 1'b1;
      if (do_pop) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
      plain_q <= plain_q + (AW+1)'(push_plain) - (AW+1)'(pop_plain);
    end
  end
endmodule // cprg_ucb

// file: tb/cprg_sys_agent.sv
// system agent model that accepts requests after a chosen stall
`timescale 1ns/1ps
module cprg_sys_agent (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sys_req_valid,
  input wire cprg_pkg::cprg_req_type sys_req,
  input wire logic [7:0] stall,
  output logic sys_accept
);
  cprg_pkg::cprg_req_type got[$];
  logic [7:0] wait_q;
  // a stall of all ones holds the request off indefinitely
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      got.delete();
      wait_q <= 8'h00;
      sys_accept <= 1'b0;
    end else if (sys_accept && sys_req_valid) begin
      got.push_back(sys_req);
      wait_q <= 8'h00;
      sys_accept <= 1'b0;
    end else if (sys_req_valid) begin
      wait_q <= wait_q + 8'h01;
      sys_accept <= wait_q >= stall && stall != 8'hff;
    end
  end
endmodule // cprg_sys_agent

// file: tb/cprg_top_chk.sv
// port checker for the cache policy request generator
`timescale 1ns/1ps
module cprg_top_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sys_accept,
  input wire logic sys_req_valid,
  input wire cprg_pkg::cprg_req_type sys_req,
  input wire logic barrier_hold
);
  logic acc_wr;
  logic mapped;
  logic bar_wr;
  // mapped-segment access written while the request port is idle
  assign acc_wr = psel && penable && pready && pwrite && paddr == cprg_pkg::REG_ACCESS
    && pwdata[1:0] == 2'h0 && !sys_req_valid;
  assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
  assign bar_wr = psel && penable && pready && pwrite && paddr == cprg_pkg::REG_UCB && pwdata[0];
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  a_ready_after_setup: assert property (psel && !penable |=> pready && psel && penable)
    else $error("pready missing after setup");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_slverr_map: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match address map");
  a_req_holds: assert property (
    sys_req_valid && !sys_accept |=> sys_req_valid && $stable(sys_req))
    else $error("request changed before acceptance");
  a_barrier_cause: assert property ($rose(barrier_hold) |-> $past(bar_wr) || $past(bar_wr, 2))
    else $error("barrier hold rose without barrier");
  a_noncoh_kind: assert property (acc_wr && pwdata[4:2] == 3'h3 |=> !sys_req_valid
    || sys_req.kind inside {cprg_pkg::RQ_NONCOH_BLOCK_READ, cprg_pkg::RQ_UPGRADE})
    else $error("wrong request for noncoherent access");
  a_excl_kind: assert property (acc_wr && pwdata[4:2] == 3'h4 |=> !sys_req_valid
    || sys_req.kind inside {cprg_pkg::RQ_COH_READ_EXCL, cprg_pkg::RQ_UPGRADE})
    else $error("wrong request for coherent exclusive access");
  a_shared_kind: assert property (acc_wr && pwdata[4:2] == 3'h5 && !pwdata[7]
    |=> !sys_req_valid || sys_req.kind == cprg_pkg::RQ_COH_READ_SHARED)
    else $error("wrong request for exclusive on write load");
  a_wr_excl_kind: assert property (acc_wr && pwdata[4:2] == 3'h5 && pwdata[7]
    |=> !sys_req_valid || sys_req.kind inside {cprg_pkg::RQ_COH_READ_EXCL, cprg_pkg::RQ_UPGRADE})
    else $error("wrong request for exclusive on write store");
endmodule // cprg_top_chk

bind cprg_top cprg_top_chk u_chk (
  .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .sys_accept(sys_accept), .sys_req_valid(sys_req_valid), .sys_req(sys_req),
  .barrier_hold(barrier_hold)
);

// file: tb/tb_cprg_top.sv
// self-checking bench for the cache policy request generator
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb_cprg_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] stall = 8'h00;
  logic [31:0] prdata, rd, t[9], c[4];
  logic pready, pslverr, sys_accept, sys_req_valid, barrier_hold, err;
  cprg_pkg::cprg_req_type sys_req;
  cprg_pkg::cprg_req_kind_type ek[4];
  int miscompares = 0;
  int cmp_count = 0;
  cprg_top DUT (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sys_accept(sys_accept), .sys_req_valid(sys_req_valid), .sys_req(sys_req),
    .barrier_hold(barrier_hold));
  cprg_sys_agent agent (.mclk(mclk), .rst(rst), .sys_req_valid(sys_req_valid),
    .sys_req(sys_req), .stall(stall), .sys_accept(sys_accept));
  initial forever #10 mclk = ~mclk;
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic rst_pulse;
    rst <= 1'b1;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, e, input string n);
    apb(1'b0, a, 32'h0);
    `CHK(n, e, rd & m)
  endtask
  task automatic wreq;
    while (sys_req_valid !== 1'b1) @(posedge mclk);
  endtask
  task automatic wgot(input int n);
    while (agent.got.size() < n) @(posedge mclk);
    // let the design retire the accepted request before anything is read back
    repeat (2) @(posedge mclk);
  endtask
  function automatic logic [31:0] acc(input int sg, al, sz, st, va);
    return {19'h0, va[2:0], 2'b00, st[0], sz[1:0], al[2:0], sg[1:0]};
  endfunction
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    close_out;
  end
  initial begin
    rst_pulse;
    rchk(8'h00, 32'h7ff, 32'h300, "config");
    rchk(8'h0c, 32'h3ff, 32'h0, "status");
    rchk(8'h18, 32'hf, 32'h1, "ucb");
    apb(1'b1, 8'h00, 32'h315);
    rchk(8'h00, 32'h7ff, 32'h315, "config");
    apb(1'b1, 8'h00, 32'h306);
    rchk(8'h00, 32'h7ff, 32'h305, "config");
    apb(1'b0, 8'h1c, 32'h0);
    `CHK("slverr", 1'b1, err)
    // uncached codes from all three sources, reserved and accelerated codes from the mapped source
    apb(1'b1, 8'h00, 32'h205);
    t = '{acc(0, 2, 1, 0, 0), acc(0, 2, 2, 1, 0), acc(0, 0, 1, 0, 0), acc(0, 1, 0, 1, 0),
      acc(0, 6, 2, 0, 0), acc(0, 7, 1, 0, 0), acc(1, 3, 1, 0, 0), acc(2, 3, 2, 0, 2),
      acc(0, 7, 0, 1, 0)};
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, 8'h08, 32'h100 * i);
      apb(1'b1, 8'h04, t[i]);
      wreq;
      `CHK("kind", t[i][7] ? cprg_pkg::RQ_UNC_WRITE : cprg_pkg::RQ_UNC_READ, sys_req.kind)
      `CHK("size", t[i][6:5], sys_req.size)
      `CHK("addr", 32'h100 * i, sys_req.addr)
    end
    c = '{acc(0, 3, 3, 0, 0), acc(0, 4, 3, 1, 0), acc(0, 5, 3, 0, 0), acc(0, 5, 3, 1, 0)};
    ek = '{cprg_pkg::RQ_NONCOH_BLOCK_READ, cprg_pkg::RQ_COH_READ_EXCL,
      cprg_pkg::RQ_COH_READ_SHARED, cprg_pkg::RQ_COH_READ_EXCL};
    for (int i = 0; i < 4; i++) begin
      rst_pulse;
      apb(1'b1, 8'h04, c[i]);
      wreq;
      `CHK("miss kind", ek[i], sys_req.kind)
    end
    rst_pulse;
    apb(1'b1, 8'h04, c[2]);
    wgot(1);
    apb(1'b1, 8'h14, 32'hf);
    rchk(8'h0c, 32'h200, 32'h0, "owned");
    apb(1'b1, 8'h04, c[3]);
    wreq;
    `CHK("hit kind", cprg_pkg::RQ_UPGRADE, sys_req.kind)
    apb(1'b1, 8'h14, 32'h2);
    rchk(8'h0c, 32'h200, 32'h200, "owned");
    apb(1'b1, 8'h14, 32'h20);
    rchk(8'h0c, 32'h200, 32'h0, "owned");
    rst_pulse;
    apb(1'b1, 8'h04, c[1]);
    wgot(1);
    apb(1'b1, 8'h14, 32'h9);
    rchk(8'h0c, 32'h200, 32'h0, "owned");
    apb(1'b1, 8'h14, 32'h2);
    rchk(8'h0c, 32'h200, 32'h200, "owned");
    apb(1'b1, 8'h14, 32'h10);
    rchk(8'h0c, 32'h200, 32'h0, "owned");
    // writeback is refused while l1 still holds dirty data
    apb(1'b1, 8'h04, c[0] | 32'h200);
    rchk(8'h0c, 32'h1, 32'h1, "l1 dirty");
    apb(1'b1, 8'h10, 32'h1);
    `CHK("writeback", 1'b0, sys_req_valid)
    apb(1'b1, 8'h04, c[0]);
    apb(1'b1, 8'h10, 32'h1);
    wreq;
    `CHK("writeback", cprg_pkg::RQ_WRITEBACK, sys_req.kind)
    // plain uncached store and load held by a stalling agent
    rst_pulse;
    stall <= 8'hff;
    apb(1'b1, 8'h08, 32'h2000);
    apb(1'b1, 8'h04, acc(0, 2, 1, 1, 0));
    apb(1'b1, 8'h18, 32'h1);
    apb(1'b1, 8'h08, 32'h3000);
    apb(1'b1, 8'h04, acc(0, 2, 1, 0, 0));
    `CHK("barrier", 1'b1, barrier_hold)
    rchk(8'h18, 32'h8, 32'h8, "load wait");
    stall <= 8'h00;
    wgot(2);
    `CHK("first", cprg_pkg::RQ_UNC_WRITE, agent.got[0].kind)
    `CHK("second", 32'h3000, agent.got[1].addr)
    rchk(8'h18, 32'h9, 32'h1, "ucb");
    `CHK("barrier", 1'b0, barrier_hold)
    // sequential accelerated word stores gather into one block
    rst_pulse;
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 8'h08, 32'h4000 + 4 * i);
      apb(1'b1, 8'h04, acc(0, 7, 1, 1, 0));
    end
    apb(1'b1, 8'h18, 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    `CHK("barrier", 1'b0, barrier_hold)
    wgot(1);
    `CHK("gather", cprg_pkg::RQ_BLOCK_WRITE, agent.got[0].kind)
    `CHK("gather size", 2'h3, agent.got[0].size)
    close_out;
  end
endmodule // tb_cprg_top
